// >>> lcd_ladder_power_sequencer.sv
// lcd prescaler, bias ladder power sequencing and reference gating
// What this block does
// - frame prescaler is a four-bit counter
// - prescaler count is neither readable nor writable
// - division ratios from 1:1 to 1:16
// - static, half and third bias selectable
// - half bias shorts middle ladder resistor
// - inactive display forces ladder off
// - disabled ladder disconnects every section
// - interval A after transition, then B
// - A power field picks ladder level
// - B power field picks ladder level
// - A duration counts 32 kHz clocks
// - type A: n of A, 16-n of B
// - type B: n of A, 32-n of B
// - timing from five-bit 32 kHz prescaler
// - seven-tap contrast ladder, 111 is maximum
// - inactive display opens contrast ladder
// - inactive display turns reference off
// - reference sourced from supply or fixed reference
// - no reference disables contrast control
// - idle enable drops buffer during interval B
// - fixed reference requested automatically when needed
// - idle clear keeps buffer independent of interval
`timescale 1ns/1ps
`include "lcd_ladder_cfg.svh"
module lcd_ladder_power_sequencer
	import lcd_ladder_pkg::*;
(
	input  wire logic              core_clk_i,
	input  wire logic              rst_i,
	input  wire reg_req_type       req_i,
	output logic       [7:0]       rdata_o,
	input  wire logic              tick_32k_i,
	input  wire logic              seg_change_i,
	output logic                   base_tick_o,
	output logic                   frame_tick_o,
	output ladder_switch_type      ladder_o,
	output contrast_type           contrast_o,
	output reference_type          reference_o
);

	logic [7:0]        frame_prescale_register;
	logic [7:0]        control;
	logic [7:0]        reference_ladder_control;
	logic [7:0]        contrast_reg;
	logic [7:0]        reference_reg;
	logic [4:0]        phase_count;
	logic [4:0]        period_last;
	logic [3:0]        frame_count;
	logic              base_wrap;
	logic              transition;
	logic [6:0]        tap_therm;
	interval_type      cur_interval;
	power_level_type   next_power;
	ladder_switch_type next_ladder;
	contrast_type      next_contrast;
	reference_type     next_reference;
	logic [7:0]        next_rdata;

	logic              display_module_active;
	logic              half_bias_select;
	logic              static_bias_select;
	logic              waveform_type_select;
	logic              fixed_ref_select;
	logic [1:0]        ladder_a_power_level;
	logic [1:0]        ladder_b_power_level;
	logic [2:0]        ladder_a_duration;
	logic [2:0]        contrast_tap_select;
	logic              ref_enable_req;
	logic              reference_idle_enable;
	logic              ref_live;

	assign display_module_active = control[`CTL_ACTIVE];
	assign half_bias_select      = control[`CTL_HALF];
	assign static_bias_select    = control[`CTL_STATIC];
	assign waveform_type_select  = control[`CTL_WAVE];
	assign fixed_ref_select      = control[`CTL_REF_SRC];
	assign ladder_a_power_level  =
		reference_ladder_control[`LAD_A_HI:`LAD_A_LO];
	assign ladder_b_power_level  =
		reference_ladder_control[`LAD_B_HI:`LAD_B_LO];
	assign ladder_a_duration     =
		reference_ladder_control[`LAD_DUR_HI:`LAD_DUR_LO];
	assign contrast_tap_select   = contrast_reg[2:0];
	assign ref_enable_req        = reference_reg[`REF_ENABLE];
	assign reference_idle_enable = reference_reg[`REF_IDLE];

	// register writes; the prescaler counter itself has no address
	// select field only
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			frame_prescale_register <= `RESET_BYTE;
		else if (req_i.wr && req_i.addr == `REG_PRESCALE)
			frame_prescale_register <= req_i.wdata & `PRESCALE_MASK;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			control <= `RESET_BYTE;
		else if (req_i.wr && req_i.addr == `REG_CONTROL)
			control <= {3'h0, req_i.wdata[4:0]};
	end

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			reference_ladder_control <= `RESET_BYTE;
		else if (req_i.wr && req_i.addr == `REG_LADDER)
			reference_ladder_control <= req_i.wdata & `LADDER_MASK;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			contrast_reg <= `RESET_BYTE;
		else if (req_i.wr && req_i.addr == `REG_CONTRAST)
			contrast_reg <= req_i.wdata & `CONTRAST_MASK;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			reference_reg <= `RESET_BYTE;
		else if (req_i.wr && req_i.addr == `REG_REFERENCE)
			reference_reg <= req_i.wdata & `REFERENCE_MASK;
	end

	// read data stand in the cycle after the strobe only
	always_comb
	begin
		next_rdata = 8'h00;
		if (req_i.rd)
		begin
			case (req_i.addr)
				`REG_PRESCALE:  next_rdata = frame_prescale_register;
				`REG_CONTROL:   next_rdata = control;
				`REG_LADDER:    next_rdata = reference_ladder_control;
				`REG_CONTRAST:  next_rdata = contrast_reg;
				`REG_REFERENCE: next_rdata = reference_reg;
				`REG_STATUS:    next_rdata = {2'h0,
					reference_o.ref_buffer_en, reference_o.enable,
					contrast_o.open_ladder, ladder_o.power,
					(cur_interval == interval_a)};
				default:        next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			rdata_o <= 8'h00;
		else
			rdata_o <= next_rdata;
	end

	assign period_last = waveform_type_select ? `TYPE_B_LAST
		: `TYPE_A_LAST;

	tick_divider #(
		.WIDTH(5)
	) u_base_prescaler (
		.core_clk_i(core_clk_i),
		.rst_i     (rst_i),
		.tick_i    (tick_32k_i),
		.restart_i (seg_change_i),
		.last_i    (period_last),
		.count_o   (phase_count),
		.wrap_o    (base_wrap)
	);

	assign transition = base_wrap || seg_change_i;

	// wrap at select gives n+1 division
	tick_divider #(
		.WIDTH(4)
	) u_frame_prescaler (
		.core_clk_i(core_clk_i),
		.rst_i     (rst_i),
		.tick_i    (base_wrap),
		.restart_i (1'b0),
		.last_i    (frame_prescale_register[3:0]),
		.count_o   (frame_count),
		.wrap_o    (frame_tick_o)
	);

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
			base_tick_o <= 1'b0;
		else
			base_tick_o <= base_wrap;
	end

	// count n of A clocks, zero means always B
	always_comb
	begin
		if (ladder_a_duration != 3'h0
			&& phase_count < {2'h0, ladder_a_duration})
			cur_interval = interval_a;
		else
			cur_interval = interval_b;
	end

	// level by interval, off when idle
	always_comb
	begin
		if (!display_module_active)
			next_power = pwr_off;
		else if (cur_interval == interval_a)
			next_power = power_level_type'(ladder_a_power_level);
		else
			next_power = power_level_type'(ladder_b_power_level);
	end

	// bias switches, all open when off
	always_comb
	begin
		next_ladder.power         = next_power;
		next_ladder.connected     = (next_power != pwr_off);
		next_ladder.mid_taps_used = next_ladder.connected
			&& !static_bias_select;
		next_ladder.mid_short     = next_ladder.mid_taps_used
			&& half_bias_select;
	end

	assign ref_live = display_module_active && ref_enable_req;

	contrast_tap_decoder u_taps (
		.select_i(contrast_tap_select),
		.taps_o  (tap_therm)
	);

	always_comb
	begin
		next_contrast.open_ladder = !ref_live;
		next_contrast.taps        = ref_live ? tap_therm : 7'h00;
	end

	always_comb
	begin
		next_reference.enable            = ref_live;
		next_reference.from_fixed_ref    = ref_live && fixed_ref_select;
		next_reference.from_io           = ref_live && !fixed_ref_select;
		next_reference.ref_buffer_en     = next_reference.from_fixed_ref
			&& !(reference_idle_enable
			&& cur_interval == interval_b);
		next_reference.fixed_ref_request = next_reference.ref_buffer_en;
	end

	// outputs from flip-flops so the analog switches never glitch
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			ladder_o    <= '{pwr_off, 1'b0, 1'b0, 1'b0};
			contrast_o  <= '{1'b1, 7'h00};
			reference_o <= '0;
		end
		else
		begin
			ladder_o    <= next_ladder;
			contrast_o  <= next_contrast;
			reference_o <= next_reference;
		end
	end

	sequence trans_s;
		transition && !rst_i && ladder_a_duration != 3'h0;
	endsequence

	// a write in the transition cycle may clear the duration
	sequence a_entry_s;
		##1 phase_count == 5'h00
			&& (cur_interval == interval_a || ladder_a_duration == 3'h0);
	endsequence

	property after_trans_p;
		@(posedge core_clk_i) disable iff (rst_i)
		trans_s |-> a_entry_s;
	endproperty

	chk_a_after_trans: assert property (after_trans_p)
		else $error("interval A not entered after transition");

	chk_half_short: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		ladder_o.mid_short |-> $past(half_bias_select)
			&& ladder_o.connected && !$past(static_bias_select))
		else $error("middle resistor shorted without half bias");

	chk_inactive_off: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		$past(!display_module_active) && !$past(rst_i)
		|-> ladder_o.power == pwr_off && contrast_o.open_ladder
			&& !reference_o.enable)
		else $error("ladder or reference alive while inactive");

	chk_ladder_open: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		ladder_o.power == pwr_off |-> !ladder_o.connected
			&& !ladder_o.mid_short && !ladder_o.mid_taps_used)
		else $error("ladder section connected while off");

	chk_level_a: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		display_module_active && cur_interval == interval_a
		|=> ladder_o.power == $past(ladder_a_power_level))
		else $error("interval A level mismatch");

	chk_level_b: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		display_module_active && cur_interval == interval_b
		|=> ladder_o.power == $past(ladder_b_power_level))
		else $error("interval B level mismatch");

	chk_a_span: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		cur_interval == interval_a |-> ladder_a_duration != 3'h0
			&& phase_count < 5'(ladder_a_duration))
		else $error("interval A outside programmed length");

	chk_period_wrap: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		base_wrap |-> phase_count ==
			(waveform_type_select ? 5'h1f : 5'h0f)
			##1 phase_count == 5'h00)
		else $error("phase period length wrong");

	chk_frame_ratio: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		frame_tick_o |-> frame_count == frame_prescale_register[3:0])
		else $error("frame prescaler ratio wrong");

	chk_buffer_idle: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		reference_idle_enable && cur_interval == interval_b
		|=> !reference_o.ref_buffer_en)
		else $error("buffer on during idle interval B");

	chk_fixed_ref_auto: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		ref_live && fixed_ref_select && !reference_idle_enable
		|=> reference_o.fixed_ref_request && reference_o.ref_buffer_en)
		else $error("fixed reference not requested");

	chk_no_ref_open: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		!ref_live |=> contrast_o.open_ladder && contrast_o.taps == 7'h00)
		else $error("contrast active without reference");

endmodule

// >>> lcd_ladder_cfg.svh
// register map, field positions, reset values and period counts
`ifndef LCD_LADDER_CFG_SVH
`define LCD_LADDER_CFG_SVH

`define REG_PRESCALE       8'h00
`define REG_CONTROL        8'h01
`define REG_LADDER         8'h02
`define REG_CONTRAST       8'h03
`define REG_REFERENCE      8'h04
`define REG_STATUS         8'h05

`define RESET_BYTE         8'h00
`define LADDER_MASK        8'hf7
`define PRESCALE_MASK      8'h0f
`define CONTRAST_MASK      8'h07
`define REFERENCE_MASK     8'ha0

`define CTL_ACTIVE         0
`define CTL_HALF           1
`define CTL_STATIC         2
`define CTL_WAVE           3
`define CTL_REF_SRC        4

`define LAD_A_HI           7
`define LAD_A_LO           6
`define LAD_B_HI           5
`define LAD_B_LO           4
`define LAD_DUR_HI         2
`define LAD_DUR_LO         0

`define REF_ENABLE         7
`define REF_IDLE           5

`define TYPE_A_LAST        5'h0f
`define TYPE_B_LAST        5'h1f

`endif

// >>> lcd_ladder_pkg.sv
// types shared by the ladder sequencer files
package lcd_ladder_pkg;

	typedef enum logic [1:0] {pwr_off, pwr_low, pwr_medium, pwr_high}
		power_level_type;

	typedef enum logic {interval_a, interval_b} interval_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_type;

	typedef struct packed {
		power_level_type power;
		logic            connected;
		logic            mid_short;
		logic            mid_taps_used;
	} ladder_switch_type;

	typedef struct packed {
		logic       open_ladder;
		logic [6:0] taps;
	} contrast_type;

	typedef struct packed {
		logic enable;
		logic from_fixed_ref;
		logic from_io;
		logic ref_buffer_en;
		logic fixed_ref_request;
	} reference_type;

endpackage

// >>> tick_divider.sv
// wrapping tick counter with restart, used for both prescalers
`timescale 1ns/1ps
module tick_divider #(
	parameter int WIDTH = 4
) (
	input  wire logic             core_clk_i,
	input  wire logic             rst_i,
	input  wire logic             tick_i,
	input  wire logic             restart_i,
	input  wire logic [WIDTH-1:0] last_i,
	output logic      [WIDTH-1:0] count_o,
	output logic                  wrap_o
);

	always_ff @(posedge core_clk_i)
	begin
		if (rst_i || restart_i)
			count_o <= '0;
		else if (tick_i)
			count_o <= (count_o == last_i) ? '0 : count_o + 1'b1;
	end

	assign wrap_o = tick_i && !restart_i && (count_o == last_i);

endmodule

// >>> contrast_tap_decoder.sv
// contrast select to seven-tap thermometer of inserted resistors
`timescale 1ns/1ps
module contrast_tap_decoder (
	input  wire logic [2:0] select_i,
	output logic      [6:0] taps_o
);

	always_comb
	begin
		for (int k = 0; k < 7; k++)
			taps_o[k] = (3'(k) < select_i);
	end

endmodule

// >>> lcd_glass_model.sv
// glass side model: 32 kHz ticks, segment changes, bias levels seen
`timescale 1ns/1ps
module lcd_glass_model
	import lcd_ladder_pkg::*;
(
	input  wire logic              core_clk_i,
	input  wire logic              rst_i,
	input  wire logic              seg_req_i,
	input  wire ladder_switch_type ladder_i,
	output logic                   tick_32k_o,
	output logic                   seg_change_o,
	output logic [2:0]             levels_o
);
	logic [1:0] cnt;
	logic       pend;

	// change lands one cycle after a tick, so none is ever dropped
	always_ff @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			cnt <= 2'h0;
			pend <= 1'b0;
			tick_32k_o <= 1'b0;
			seg_change_o <= 1'b0;
		end
		else
		begin
			cnt <= cnt + 2'h1;
			tick_32k_o <= (cnt == 2'h3);
			seg_change_o <= pend && (cnt == 2'h0);
			if (seg_req_i)
				pend <= 1'b1;
			else if (cnt == 2'h0)
				pend <= 1'b0;
		end
	end

	// distinct voltages the glass sees
	always_comb
	begin
		if (!ladder_i.connected)
			levels_o = 3'h0;
		else if (!ladder_i.mid_taps_used)
			levels_o = 3'h2;
		else if (ladder_i.mid_short)
			levels_o = 3'h3;
		else
			levels_o = 3'h4;
	end
endmodule

// >>> test_lcd_ladder_power_sequencer.sv
// self-checking bench for the ladder power sequencer
`timescale 1ns/1ps
`include "lcd_ladder_cfg.svh"
module test_lcd_ladder_power_sequencer
	import lcd_ladder_pkg::*;
;
	logic              core_clk;
	logic              rst;
	reg_req_type       req;
	logic [7:0]        rdata;
	logic              tick;
	logic              seg;
	logic              seg_req;
	logic              base_tick;
	logic              frame_tick;
	ladder_switch_type ladder;
	contrast_type      contrast;
	reference_type     reference;
	logic [2:0]        levels;
	int                err_count;
	int                checked;

	lcd_ladder_power_sequencer lcd_ladder_power_sequencer_inst (
		.core_clk_i  (core_clk),
		.rst_i       (rst),
		.req_i       (req),
		.rdata_o     (rdata),
		.tick_32k_i  (tick),
		.seg_change_i(seg),
		.base_tick_o (base_tick),
		.frame_tick_o(frame_tick),
		.ladder_o    (ladder),
		.contrast_o  (contrast),
		.reference_o (reference)
	);

	lcd_glass_model lcd_glass_model_inst (
		.core_clk_i  (core_clk),
		.rst_i       (rst),
		.seg_req_i   (seg_req),
		.ladder_i    (ladder),
		.tick_32k_o  (tick),
		.seg_change_o(seg),
		.levels_o    (levels)
	);

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic conclude();
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge core_clk);
		req.wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge core_clk);
		req.rd <= 1'b0;
		#1;
		check(rdata, exp);
	endtask

	task automatic settle();
		repeat (2) @(posedge core_clk);
		#1;
	endtask

	// bounded wait for a one-cycle pulse: 0 tick, 1 change, 2 frame
	task automatic wait_sig(input int s);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 3000 && !hit; i++)
		begin
			@(posedge core_clk);
			hit = (s == 0) ? tick === 1'b1 :
				(s == 1) ? seg === 1'b1 : frame_tick === 1'b1;
		end
		if (!hit)
		begin
			check(8'h00, 8'h01);
			conclude();
		end
	endtask

	task automatic t_regs();
		logic [7:0] a [6];
		logic [7:0] m [6];
		a = '{`REG_PRESCALE, `REG_CONTROL, `REG_LADDER, `REG_CONTRAST,
			`REG_REFERENCE, 8'h06};
		m = '{8'h0f, 8'h1f, 8'hf7, 8'h07, 8'ha0, 8'h00};
		for (int i = 0; i < 6; i++)
		begin
			rd_chk(a[i], `RESET_BYTE);
			wr(a[i], 8'hff);
			rd_chk(a[i], m[i]);
		end
		$display("test regs done");
	endtask

	task automatic t_frame(input logic [3:0] n);
		int c;
		int w;
		c = 0;
		wr(`REG_CONTROL, 8'h01);
		wr(`REG_PRESCALE, {4'h0, n});
		wait_sig(2);
		for (w = 0; w < 3000; w++)
		begin
			@(posedge core_clk);
			if (frame_tick === 1'b1)
				break;
			if (base_tick === 1'b1)
				c++;
		end
		if (w == 3000)
		begin
			check(8'h00, 8'h01);
			conclude();
		end
		check(c[7:0], {4'h0, n} + 8'h01);
		$display("test frame done");
	endtask

	task automatic t_walk(input logic [2:0] dur, input logic wave,
		input logic idle);
		int   per;
		logic a_now;
		per = wave ? 32 : 16;
		wr(`REG_CONTROL, {3'h0, 1'b1, wave, 3'h1});
		wr(`REG_LADDER, {2'h3, 2'h1, 1'b0, dur});
		wr(`REG_REFERENCE, {2'h2, idle, 5'h00});
		@(posedge core_clk);
		seg_req <= 1'b1;
		@(posedge core_clk);
		seg_req <= 1'b0;
		wait_sig(1);
		for (int k = 0; k < 34; k++)
		begin
			if (k > 0)
				wait_sig(0);
			settle();
			a_now = (k % per) < dur;
			check(ladder.power, a_now ? pwr_high : pwr_low);
			check(reference.ref_buffer_en, !(idle && !a_now));
			check(reference.fixed_ref_request, !(idle && !a_now));
			check(reference.from_fixed_ref, 1'b1);
		end
		$display("test walk done");
	endtask

	task automatic t_bias();
		wr(`REG_LADDER, 8'hf0);
		for (int i = 0; i < 3; i++)
		begin
			wr(`REG_CONTROL, {5'h0, i == 2, i == 1, 1'b1});
			settle();
			check({5'h0, levels}, 8'(4 - i));
			check(ladder.mid_short, i == 1);
		end
		rd_chk(`REG_CONTROL, 8'h05);
		$display("test bias done");
	endtask

	task automatic t_contrast();
		wr(`REG_CONTROL, 8'h01);
		wr(`REG_REFERENCE, 8'h80);
		for (int s = 0; s < 8; s++)
		begin
			wr(`REG_CONTRAST, 8'(s));
			settle();
			check(contrast.taps, (8'h01 << s) - 8'h01);
			check(contrast.open_ladder, 1'b0);
			check(reference.from_io, 1'b1);
		end
		wr(`REG_REFERENCE, 8'h00);
		settle();
		check(contrast.open_ladder, 1'b1);
		rd_chk(`REG_STATUS, 8'h0e);
		$display("test contrast done");
	endtask

	task automatic t_inactive();
		wr(`REG_LADDER, 8'hf0);
		wr(`REG_REFERENCE, 8'h80);
		wr(`REG_CONTROL, 8'h00);
		settle();
		check(ladder.power, pwr_off);
		check({5'h0, levels}, 8'h00);
		check(contrast.open_ladder, 1'b1);
		check(reference.enable, 1'b0);
		rd_chk(`REG_STATUS, 8'h08);
		$display("test inactive done");
	endtask

	initial
	begin
		req = '0;
		rst = 1'b1;
		seg_req = 1'b0;
		err_count = 0;
		checked = 0;
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		t_regs();
		t_frame(4'hf);
		t_frame(4'h2);
		t_frame(4'h0);
		t_walk(3'h0, 1'b0, 1'b1);
		t_walk(3'h1, 1'b0, 1'b0);
		t_walk(3'h7, 1'b0, 1'b1);
		t_walk(3'h7, 1'b1, 1'b0);
		t_walk(3'h3, 1'b1, 1'b1);
		t_bias();
		t_contrast();
		t_inactive();
		conclude();
	end
endmodule
